// >>> wlc_pkg.sv
// Constants, types and the register map of the write leveling controller.
// Assumes an APB slave on pclk at 25 MHz and a DRAM on its own pins.
// Functional notes
// [RQ1] Mode one bit A7 high enters leveling
// [RQ2] Mode one bit A12 set disables outputs
// [RQ3] Termination pin switches only strobe termination
// [RQ4] Only deselect or allowed writes while leveling
// [RQ5] Exit write may update A12-A8, A2-A1
// [RQ6] One rank leveled, others outputs disabled
// [RQ7] Termination pin only after mode update delay
// [RQ8] Strobe driven low after strobe enable delay
// [RQ9] Single strobe edge after low and first-strobe delays
// [RQ10] Device returns sampled clock on data lines
// [RQ11] Data lines undefined on leveling entry
// [RQ12] Sixteen-bit device levels byte lanes separately
// [RQ13] Sweep delay, lock on 0 to 1
// [RQ14] Stop strobes, termination low, then exit write
// [RQ15] Exit waits mode cycle and update delay
// [RQ16] Termination choice depends on output disable
// [RQ17] Latency set by mode four bits A8:A6
// [RQ18] Receivers stay on through consecutive commands
// [RQ19] Normal gear latency 3, 4, 4, 5
// [RQ20] Gear-down latency 4, 4, 4, 6
// [RQ21] Wait update delay plus latency after write
// [RQ22] Space mode writes by delay plus latency
// [RQ23] Waits use newly programmed latency
`default_nettype none
package wlc_pkg;
   // APB register byte offsets
   localparam logic [7:0] WLC_CTRL_OFS = 8'h00;
   localparam logic [7:0] WLC_CFG_OFS = 8'h04;
   localparam logic [7:0] WLC_STAT_OFS = 8'h08;
   localparam logic [7:0] WLC_DLY_OFS = 8'h0c;
   localparam logic [7:0] WLC_MR1_OFS = 8'h10;
   // Control register bits
   localparam int WLC_CTRL_START = 0;
   localparam int WLC_CTRL_ABORT = 1;
   // Configuration field positions
   localparam int WLC_CFG_RATE_LO = 0; // Speed index, 2 bits
   localparam int WLC_CFG_GEAR = 2;
   localparam int WLC_CFG_CALEN = 3;
   localparam int WLC_CFG_X16 = 4;
   localparam int WLC_CFG_RANK_LO = 8; // Rank under leveling, 2 bits
   localparam int WLC_CFG_QOFF = 12;   // Output disable on leveled rank
   localparam int WLC_CFG_TERM = 13;   // Use nominal (1) or park (0)
   // Mode register bit positions
   localparam int WLC_MR1_WL = 7;
   localparam int WLC_MR1_QOFF = 12;
   localparam int WLC_MR4_CAL_LO = 6;
   // Reset values
   localparam logic [31:0] WLC_CFG_RST = 32'h0000_0000;
   localparam logic [17:0] WLC_MR1_RST = 18'h00001;
   // Times in ns and derived cycle counts at 40 ns
   localparam int WLC_CLK_NS = 40;
   localparam int WLC_MODE_UPDATE_DELAY_NS = 120;
   localparam int WLC_MODE_CMD_CYCLE_NS = 80;
   localparam int WLC_TDQSEN_NS = 200;
   localparam int WLC_STROBE_LOW_TIME_NS = 120;
   localparam int WLC_FIRST_STROBE_DELAY_NS = 400;
   localparam int WLC_FEEDBACK_DELAY_NS = 80;
   localparam int WLC_TODTOFF_NS = 80;
   localparam int WLC_MODE_UPDATE_DELAY_CYC = (WLC_MODE_UPDATE_DELAY_NS + WLC_CLK_NS - 1) / WLC_CLK_NS;
   localparam int WLC_MODE_CMD_CYCLE_CYC = (WLC_MODE_CMD_CYCLE_NS + WLC_CLK_NS - 1) / WLC_CLK_NS;
   localparam int WLC_TDQSEN_CYC =
      (WLC_TDQSEN_NS + WLC_CLK_NS - 1) / WLC_CLK_NS;
   localparam int WLC_STROBE_LOW_TIME_CYC = (WLC_STROBE_LOW_TIME_NS + WLC_CLK_NS - 1) / WLC_CLK_NS;
   localparam int WLC_FIRST_STROBE_DELAY_CYC =
      (WLC_FIRST_STROBE_DELAY_NS + WLC_CLK_NS - 1) / WLC_CLK_NS;
   localparam int WLC_FEEDBACK_DELAY_CYC = (WLC_FEEDBACK_DELAY_NS + WLC_CLK_NS - 1) / WLC_CLK_NS;
   localparam int WLC_TODTOFF_CYC =
      (WLC_TODTOFF_NS + WLC_CLK_NS - 1) / WLC_CLK_NS;
   localparam int WLC_DLY_MAX = 255;
   // Sequencer states
   typedef enum logic [3:0] {
      WLC_IDLE, WLC_MRS_OTH, WLC_MRS_ENT, WLC_ODT_ON, WLC_DQS_LOW,
      WLC_PULSE, WLC_SAMPLE, WLC_STEP, WLC_ODT_OFF, WLC_MRS_EXIT,
      WLC_MRS_REST, WLC_DONE
   } wlc_state_t;
   // Latency in clocks from speed index and gear
   function automatic logic [3:0] wlc_cal_clocks(input logic [1:0] rate,
                                                 input logic gear);
      logic [3:0] v;
      v = 4'h3;
      if (gear) begin
         v = (rate == 2'h3) ? 4'h6 : 4'h4; // RQ20
      end else if (rate == 2'h0) begin
         v = 4'h3; // RQ19
      end else if (rate == 2'h3) begin
         v = 4'h5; // RQ19
      end else begin
         v = 4'h4; // RQ19
      end
      return v;
   endfunction : wlc_cal_clocks
   // Mode four latency field code for a clock count
   function automatic logic [2:0] wlc_cal_code(input logic [3:0] clk);
      logic [2:0] c;
      c = 3'h0;
      if (clk == 4'h3) begin
         c = 3'h1;
      end else if (clk == 4'h4) begin
         c = 3'h2;
      end else if (clk == 4'h5) begin
         c = 3'h3;
      end else if (clk == 4'h6) begin
         c = 3'h4;
      end
      return c;
   endfunction : wlc_cal_code
endpackage : wlc_pkg
`default_nettype wire

// >>> wlc_sync.sv
// Two-stage synchroniser for a group of pins.
// Assumes inputs arrive asynchronously to pclk.
`default_nettype none
module wlc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r; // First stage, read only by q
   // Two flops in series
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : wlc_sync
`default_nettype wire

// >>> wlc_timer.sv
// Loadable down counter giving a done flag after a wait.
// Assumes loads come from the sequencer on pclk.
`default_nettype none
module wlc_timer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic load,
   input wire logic [7:0] count,
   // Status
   output logic done
);
   logic [7:0] cnt_r; // Cycles left
   // Count down to zero after each load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 8'h00;
      end else if (load) begin
         cnt_r <= count;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
   // Free of load, so a load decided from done cannot feed back into it
   assign done = (cnt_r == 8'h00);
endmodule : wlc_timer
`default_nettype wire

// >>> wlc_ctrl.sv
// Write leveling host sequencer with APB registers.
// Assumes the DRAM command clock is an input sampled on pclk and the
// strobe delay line lives outside; the delay setting is driven out.
`default_nettype none
module wlc_ctrl (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // DRAM command side
   output logic mrs_valid,       // One-cycle mode register write
   output logic [1:0] mrs_sel,   // 1 = mode one, 0 = mode four
   output logic [3:0] mrs_rank,  // Ranks addressed by the write
   output logic [17:0] mrs_data,
   output logic [3:0] termination_control_pin,
   // Strobe pins, split into value and enable
   output logic dqs_t_o,
   output logic dqs_c_o,
   output logic dqs_oe,
   output logic [7:0] dqs_delay, // Strobe delay setting
   // Feedback
   input wire logic [15:0] dq_i,
   input wire logic ck_i
);
   // Registers
   logic [31:0] cfg_r;
   logic [17:0] mr1_r;
   logic [7:0] dly_r, dly_nxt;
   logic [7:0] lock_lo_r, lock_hi_r;
   logic lo_done_r, hi_done_r;
   logic prev_lo_r, prev_hi_r, first_r;
   logic err_r, busy_r;
   wlc_pkg::wlc_state_t st_r, st_nxt;
   // Synchronised feedback
   logic [15:0] dq_s;
   logic ck_s;
   wlc_sync #(.W(16)) u_dq (.pclk(pclk), .presetn(presetn), .d(dq_i),
      .q(dq_s));
   wlc_sync #(.W(1)) u_ck (.pclk(pclk), .presetn(presetn), .d(ck_i),
      .q(ck_s));
   // Timer
   logic tload;
   logic [7:0] tcount;
   logic tdone;
   wlc_timer u_tmr (.pclk(pclk), .presetn(presetn), .load(tload),
      .count(tcount), .done(tdone));
   // APB decode
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire hit_ctrl = (paddr == wlc_pkg::WLC_CTRL_OFS);
   wire hit_cfg = (paddr == wlc_pkg::WLC_CFG_OFS);
   wire hit_stat = (paddr == wlc_pkg::WLC_STAT_OFS);
   wire hit_dly = (paddr == wlc_pkg::WLC_DLY_OFS);
   wire hit_mr1 = (paddr == wlc_pkg::WLC_MR1_OFS);
   wire mapped = hit_ctrl | hit_cfg | hit_stat | hit_dly | hit_mr1;
   wire start = wr && hit_ctrl && pwdata[wlc_pkg::WLC_CTRL_START] &&
      (st_r == wlc_pkg::WLC_IDLE || st_r == wlc_pkg::WLC_DONE);
   wire abort = wr && hit_ctrl && pwdata[wlc_pkg::WLC_CTRL_ABORT];
   assign pready = 1'b1;
   assign pslverr = acc && !mapped;
   // Config fields
   wire [1:0] rate = cfg_r[wlc_pkg::WLC_CFG_RATE_LO +: 2];
   wire [1:0] rank = cfg_r[wlc_pkg::WLC_CFG_RANK_LO +: 2];
   wire calen = cfg_r[wlc_pkg::WLC_CFG_CALEN];
   wire x16 = cfg_r[wlc_pkg::WLC_CFG_X16];
   wire [3:0] cal = calen ?
      wlc_pkg::wlc_cal_clocks(rate, cfg_r[wlc_pkg::WLC_CFG_GEAR]) : 4'h0;
   // Waits after a mode write, stretched by latency from new value
   wire [7:0] mod_wait = 8'(wlc_pkg::WLC_MODE_UPDATE_DELAY_CYC) + {4'h0, cal}; // RQ21
   wire [7:0] mrd_wait = calen ? mod_wait : // RQ22 RQ23
      8'(wlc_pkg::WLC_MODE_CMD_CYCLE_CYC);
   // Read data mux
   wire [31:0] stat_w = {16'h0, lock_hi_r, 1'b0, st_r, err_r, hi_done_r,
      lo_done_r};
   wire [31:0] rd_w = hit_cfg ? cfg_r :
      hit_stat ? stat_w :
      hit_dly ? {16'h0, lock_hi_r, lock_lo_r} :
      hit_mr1 ? {14'h0, mr1_r} :
      32'h0;
   // Register writes and read data capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= wlc_pkg::WLC_CFG_RST;
         mr1_r <= wlc_pkg::WLC_MR1_RST;
         prdata <= 32'h0;
      end else begin
         if (wr && hit_cfg && !busy_r) begin
            cfg_r <= pwdata;
         end
         if (wr && hit_mr1 && !busy_r) begin
            mr1_r <= pwdata[17:0];
         end
         // Captured in the setup cycle so it stands through the access
         if (psel && !penable && !pwrite) begin
            prdata <= rd_w;
         end
      end
   end
   // Lane feedback: upper byte follows upper strobe on wide parts
   wire fb_lo = dq_s[0];
   wire fb_hi = x16 ? dq_s[8] : dq_s[0]; // RQ12
   wire all_done = lo_done_r && (hi_done_r || !x16);
   // Sequencer next state
   always_comb begin
      st_nxt = st_r;
      tload = 1'b0;
      tcount = 8'h00;
      case (st_r)
         wlc_pkg::WLC_IDLE: begin
            // Space the next mode write from the latency write
            if (start) begin
               st_nxt = wlc_pkg::WLC_MRS_OTH;
               tload = 1'b1;
               tcount = mrd_wait; // RQ22 RQ23
            end
         end
         wlc_pkg::WLC_MRS_OTH: begin
            // Disable outputs of all other ranks first
            if (tdone) begin
               st_nxt = wlc_pkg::WLC_MRS_ENT;
               tload = 1'b1;
               tcount = mrd_wait;
            end
         end
         wlc_pkg::WLC_MRS_ENT: begin
            if (tdone) begin
               st_nxt = wlc_pkg::WLC_ODT_ON;
               tload = 1'b1;
               tcount = mod_wait; // RQ7
            end
         end
         wlc_pkg::WLC_ODT_ON: begin
            if (tdone) begin
               st_nxt = wlc_pkg::WLC_DQS_LOW;
               tload = 1'b1;
               tcount = 8'(wlc_pkg::WLC_TDQSEN_CYC); // RQ8
            end
         end
         wlc_pkg::WLC_DQS_LOW: begin
            if (tdone) begin
               st_nxt = wlc_pkg::WLC_PULSE;
               tload = 1'b1;
               tcount = 8'(wlc_pkg::WLC_STROBE_LOW_TIME_CYC + wlc_pkg::WLC_FIRST_STROBE_DELAY_CYC);
            end
         end
         wlc_pkg::WLC_PULSE: begin
            // One rising edge, then strobe back low
            if (tdone) begin
               st_nxt = wlc_pkg::WLC_SAMPLE;
               tload = 1'b1;
               tcount = 8'(wlc_pkg::WLC_FEEDBACK_DELAY_CYC + 2);
            end
         end
         wlc_pkg::WLC_SAMPLE: begin
            if (tdone) begin
               st_nxt = wlc_pkg::WLC_STEP;
            end
         end
         wlc_pkg::WLC_STEP: begin
            if (all_done || dly_r == 8'(wlc_pkg::WLC_DLY_MAX)) begin
               st_nxt = wlc_pkg::WLC_ODT_OFF;
               tload = 1'b1;
               tcount = 8'(wlc_pkg::WLC_TODTOFF_CYC);
            end else begin
               st_nxt = wlc_pkg::WLC_PULSE;
               tload = 1'b1;
               tcount = 8'(wlc_pkg::WLC_STROBE_LOW_TIME_CYC);
            end
         end
         wlc_pkg::WLC_ODT_OFF: begin
            if (tdone) begin
               st_nxt = wlc_pkg::WLC_MRS_EXIT;
            end
         end
         wlc_pkg::WLC_MRS_EXIT: begin
            st_nxt = wlc_pkg::WLC_MRS_REST;
            tload = 1'b1;
            tcount = mod_wait; // RQ15
         end
         wlc_pkg::WLC_MRS_REST: begin
            if (tdone) begin
               st_nxt = wlc_pkg::WLC_DONE;
            end
         end
         default: begin
            if (start) begin
               st_nxt = wlc_pkg::WLC_MRS_OTH;
               tload = 1'b1;
               tcount = mrd_wait; // RQ22 RQ23
            end
         end
      endcase
      if (abort && st_r != wlc_pkg::WLC_IDLE && st_r != wlc_pkg::WLC_DONE &&
          st_r != wlc_pkg::WLC_MRS_EXIT && st_r != wlc_pkg::WLC_MRS_REST &&
          st_r != wlc_pkg::WLC_ODT_OFF) begin
         st_nxt = wlc_pkg::WLC_ODT_OFF; // RQ14
         tload = 1'b1;
         // Longer than the termination off time and any pending write gap
         tcount = mod_wait; // RQ22
      end
   end
   // Edge on sampled feedback: lock each lane on 0 to 1
   wire rise_lo = !first_r && !prev_lo_r && fb_lo;
   wire rise_hi = !first_r && !prev_hi_r && fb_hi;
   wire in_sample = (st_r == wlc_pkg::WLC_STEP);
   assign dly_nxt = dly_r + 8'h01; // RQ13
   // Sequencer state and leveling results
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= wlc_pkg::WLC_IDLE;
         dly_r <= 8'h00;
         lock_lo_r <= 8'h00;
         lock_hi_r <= 8'h00;
         lo_done_r <= 1'b0;
         hi_done_r <= 1'b0;
         prev_lo_r <= 1'b0;
         prev_hi_r <= 1'b0;
         first_r <= 1'b1;
         err_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         busy_r <= (st_nxt != wlc_pkg::WLC_IDLE) &&
            (st_nxt != wlc_pkg::WLC_DONE);
         if (start) begin
            dly_r <= 8'h00;
            lo_done_r <= 1'b0;
            hi_done_r <= 1'b0;
            first_r <= 1'b1;
            err_r <= 1'b0;
         end else if (in_sample) begin
            prev_lo_r <= fb_lo;
            prev_hi_r <= fb_hi;
            first_r <= 1'b0;
            if (rise_lo && !lo_done_r) begin
               lo_done_r <= 1'b1; // RQ13
               lock_lo_r <= dly_r;
            end
            if (rise_hi && !hi_done_r && x16) begin
               hi_done_r <= 1'b1; // RQ12
               lock_hi_r <= dly_r;
            end
            if (dly_r == 8'(wlc_pkg::WLC_DLY_MAX)) begin
               err_r <= !all_done;
            end else begin
               dly_r <= dly_nxt;
            end
         end
      end
   end
   // Pin drive: strobe low until pulse, termination per state
   wire odt_on = (st_r == wlc_pkg::WLC_DQS_LOW) ||
      (st_r == wlc_pkg::WLC_PULSE) || (st_r == wlc_pkg::WLC_SAMPLE) ||
      (st_r == wlc_pkg::WLC_STEP);
   wire dqs_en = odt_on && (st_r != wlc_pkg::WLC_DQS_LOW || tdone); // RQ8
   wire dqs_hi = (st_r == wlc_pkg::WLC_PULSE) && tdone; // RQ9
   // Mode register writes; mode one data from software copy with fixed bits forced, mode four from latency
   wire [17:0] mr1_oth = mr1_r | (18'h1 << wlc_pkg::WLC_MR1_QOFF); // RQ6
   wire [17:0] mr1_ent = (mr1_r | (18'h1 << wlc_pkg::WLC_MR1_WL)) &
      ~(18'h1 << wlc_pkg::WLC_MR1_QOFF) |
      ({17'h0, cfg_r[wlc_pkg::WLC_CFG_QOFF]} << wlc_pkg::WLC_MR1_QOFF);
   wire [17:0] mr1_ext = mr1_r & ~(18'h1 << wlc_pkg::WLC_MR1_WL); // RQ5
   wire [17:0] mr4_val = {9'h0, wlc_pkg::wlc_cal_code(cal), 6'h0}; // RQ17
   wire [3:0] rank_oh = 4'h1 << rank;
   // Output registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mrs_valid <= 1'b0;
         mrs_sel <= 2'h0;
         mrs_rank <= 4'h0;
         mrs_data <= 18'h0;
         termination_control_pin <= 4'h0;
         dqs_t_o <= 1'b0;
         dqs_c_o <= 1'b1;
         dqs_oe <= 1'b0;
         dqs_delay <= 8'h00;
      end else begin
         mrs_valid <= 1'b0;
         if (start) begin
            // Latency field first on every run; waits use the new value
            mrs_valid <= 1'b1;
            mrs_sel <= 2'h0;
            mrs_rank <= 4'hf;
            mrs_data <= mr4_val;
         end else if (st_r == wlc_pkg::WLC_MRS_OTH && tdone) begin
            mrs_valid <= 1'b1; // RQ4 RQ6
            mrs_sel <= 2'h1;
            mrs_rank <= ~rank_oh;
            mrs_data <= mr1_oth;
         end else if (st_r == wlc_pkg::WLC_MRS_ENT && tdone) begin
            mrs_valid <= 1'b1; // RQ1 RQ2
            mrs_sel <= 2'h1;
            mrs_rank <= rank_oh;
            mrs_data <= mr1_ent;
         end else if (st_r == wlc_pkg::WLC_MRS_EXIT) begin
            mrs_valid <= 1'b1; // RQ14 RQ15
            mrs_sel <= 2'h1;
            mrs_rank <= rank_oh;
            mrs_data <= mr1_ext;
         end
         // Nominal asks pin high, park asks it low; both give strobe term
         termination_control_pin <= (odt_on &&
            cfg_r[wlc_pkg::WLC_CFG_TERM]) ? rank_oh : 4'h0; // RQ3 RQ16
         dqs_oe <= dqs_en;
         dqs_t_o <= dqs_hi;
         dqs_c_o <= !dqs_hi;
         dqs_delay <= dly_r;
      end
   end
   // Command clock level is registered but read by nothing, not even status
   logic ck_seen_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ck_seen_r <= 1'b0;
      end else begin
         ck_seen_r <= ck_s;
      end
   end
   // Checks
   sequence s_ent;
      (st_r == wlc_pkg::WLC_MRS_ENT) && tdone;
   endsequence
   property p_odt_after_mod;
      @(posedge pclk) disable iff (!presetn)
         s_ent |=> (termination_control_pin == 4'h0) [*3];
   endproperty
   a_odt_after_mod: assert property (p_odt_after_mod) // RQ7
      else $error("termination pin raised too early");
   property p_ent_wl;
      @(posedge pclk) disable iff (!presetn)
         s_ent |=> mrs_valid && mrs_data[wlc_pkg::WLC_MR1_WL];
   endproperty
   a_ent_wl: assert property (p_ent_wl) // RQ1
      else $error("entry write lacks leveling bit");
   property p_exit_clr;
      @(posedge pclk) disable iff (!presetn)
         (st_r == wlc_pkg::WLC_MRS_EXIT) |=> mrs_valid &&
         !mrs_data[wlc_pkg::WLC_MR1_WL] && termination_control_pin == 4'h0;
   endproperty
   a_exit_clr: assert property (p_exit_clr) // RQ14
      else $error("exit write wrong");
   property p_oth_qoff;
      @(posedge pclk) disable iff (!presetn)
         (st_r == wlc_pkg::WLC_MRS_OTH && tdone) |=>
         mrs_data[wlc_pkg::WLC_MR1_QOFF] && !(|(mrs_rank & rank_oh));
   endproperty
   a_oth_qoff: assert property (p_oth_qoff) // RQ6
      else $error("other ranks not disabled");
   property p_single_edge;
      @(posedge pclk) disable iff (!presetn)
         $rose(dqs_t_o) |=> !dqs_t_o;
   endproperty
   a_single_edge: assert property (p_single_edge) // RQ9
      else $error("strobe pulse too long");
   property p_dqs_needs_odt;
      @(posedge pclk) disable iff (!presetn)
         $rose(dqs_oe) |-> $past(st_r) == wlc_pkg::WLC_DQS_LOW;
   endproperty
   a_dqs_needs_odt: assert property (p_dqs_needs_odt) // RQ8
      else $error("strobe driven before enable delay");
   property p_rest_wait;
      @(posedge pclk) disable iff (!presetn)
         (st_r == wlc_pkg::WLC_MRS_EXIT) |=> mrs_valid ##1 !mrs_valid [*3];
   endproperty
   a_rest_wait: assert property (p_rest_wait) // RQ15
      else $error("command too soon after exit");
   property p_cal_wait;
      @(posedge pclk) disable iff (!presetn)
         (calen && st_r == wlc_pkg::WLC_MRS_OTH && tdone) |=>
         mrs_valid ##1 !mrs_valid [*6];
   endproperty
   a_cal_wait: assert property (p_cal_wait) // RQ22
      else $error("mode writes too close under latency");
   property p_lock;
      @(posedge pclk) disable iff (!presetn)
         (in_sample && rise_lo && !lo_done_r && !start) |=>
         lo_done_r && lock_lo_r == $past(dly_r);
   endproperty
   a_lock: assert property (p_lock) // RQ13
      else $error("delay not locked on rise");
endmodule : wlc_ctrl
`default_nettype wire

// >>> wlc_dram_model.sv
// Behavioural DRAM facing the leveling controller: mode bits and feedback.
// Assumes commands and strobe arrive as registered pins on pclk.
`default_nettype none
module wlc_dram_model #(
   parameter int LOCK_LO = 9, // Delay step where the lower lane sees CK high
   parameter int LOCK_HI = 13 // Same for the upper lane
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Commands
   input wire logic mrs_valid,
   input wire logic [1:0] mrs_sel,
   input wire logic [3:0] mrs_rank,
   input wire logic [17:0] mrs_data,
   input wire logic [3:0] termination_control_pin,
   // Strobe
   input wire logic dqs_t_o,
   input wire logic dqs_oe,
   input wire logic [7:0] dqs_delay,
   // Feedback
   output logic [15:0] dq_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wl_r, qoff_r; // Per rank leveling mode and output disable
   logic [2:0] cal_r; // Latency code
   logic [1:0] fb_r; // Lane samples
   logic fb_ok, dqs_d; // Feedback defined, previous strobe
   logic [15:0] junk; // Undefined drive before the first sample
   int gap, since_ent, viol, min_gap;
   // Released lines float to the controller's pull-up
   assign dq_i = |(wl_r & ~qoff_r) ? (fb_ok ? {{8{fb_r[1]}}, {8{fb_r[0]}}}
      : junk) : 16'hffff;
   assign min_gap = (cal_r != 3'h0) ? wlc_pkg::WLC_MODE_UPDATE_DELAY_CYC + cal_r + 2
      : wlc_pkg::WLC_MODE_CMD_CYCLE_CYC;
   // Mode registers, strobe sampling and controller timing watch
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wl_r <= 4'h0;
         qoff_r <= 4'h0;
         cal_r <= 3'h0;
         fb_r <= 2'h0;
         fb_ok <= 1'b0;
         dqs_d <= 1'b0;
         junk <= 16'h5a5a;
         gap <= 999;
         since_ent <= 999;
         viol <= 0;
      end else begin
         junk <= ~junk;
         dqs_d <= dqs_t_o & dqs_oe;
         gap <= gap + 1;
         since_ent <= since_ent + 1;
         // Strobe termination is on in both pin states while leveling
         if (dqs_oe && since_ent < wlc_pkg::WLC_MODE_UPDATE_DELAY_CYC +
             wlc_pkg::WLC_TDQSEN_CYC) viol <= viol + 1;
         if (|(termination_control_pin & wl_r) &&
             since_ent < wlc_pkg::WLC_MODE_UPDATE_DELAY_CYC) viol <= viol + 1;
         // Delay line position stands in for the clock phase seen
         if (dqs_oe && dqs_t_o && !dqs_d && wl_r != 4'h0) begin
            fb_r <= {dqs_delay >= LOCK_HI, dqs_delay >= LOCK_LO};
            fb_ok <= 1'b1;
         end
         if (mrs_valid) begin
            gap <= 1;
            if (gap < min_gap) viol <= viol + 1;
            if (mrs_sel == 2'h0) begin
               if (wl_r != 4'h0) viol <= viol + 1;
               cal_r <= mrs_data[8:6];
            end else begin
               for (int i = 0; i < 4; i++) begin
                  if (mrs_rank[i]) begin
                     wl_r[i] <= mrs_data[7];
                     qoff_r[i] <= mrs_data[12];
                  end
               end
               if (mrs_data[7] && (qoff_r | mrs_rank) != 4'hf)
                  viol <= viol + 1;
               if (mrs_data[7]) since_ent <= 1;
               else fb_ok <= 1'b0;
            end
         end
      end
   end
endmodule : wlc_dram_model
`default_nettype wire

// >>> wlc_ctrl_bench.sv
// Self-checking bench: APB drives the leveling controller against a DRAM.
// Assumes wlc_pkg, wlc_ctrl and wlc_dram_model are compiled first.
`default_nettype none
module wlc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LO = 9; // Lane lock steps given to the model
   localparam int HI = 13;
   logic pclk = 1'b0, presetn = 1'b0, ck_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, cfg;
   logic pready, pslverr, err, mrs_valid, dqs_t_o, dqs_c_o, dqs_oe;
   logic [1:0] mrs_sel;
   logic [3:0] mrs_rank, termination_control_pin;
   logic [17:0] mrs_data;
   logic [7:0] dqs_delay;
   logic [15:0] dq_i;
   int mismatches = 0, tests_run = 0;
   // Latency codes indexed by {gear, rate}; last run has latency off
   logic [2:0] cal_code [9] = '{3'h1, 3'h2, 3'h2, 3'h3,
                                3'h2, 3'h2, 3'h2, 3'h4, 3'h0};
   always #20 pclk = ~pclk;
   // Command clock runs free at eight pclk periods, toggling on falling pclk edges
   always #160 ck_i = ~ck_i;
   // Complement strobe opposes the true strobe whenever driven
   always @(negedge pclk) begin
      if (dqs_oe) chk({31'h0, dqs_c_o}, {31'h0, !dqs_t_o});
   end
   wlc_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .mrs_valid, .mrs_sel, .mrs_rank,
      .mrs_data, .termination_control_pin, .dqs_t_o, .dqs_c_o, .dqs_oe,
      .dqs_delay, .dq_i, .ck_i);
   wlc_dram_model #(.LOCK_LO(LO), .LOCK_HI(HI)) i_dram (.pclk, .presetn,
      .mrs_valid, .mrs_sel, .mrs_rank, .mrs_data, .termination_control_pin,
      .dqs_t_o, .dqs_oe, .dqs_delay, .dq_i);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // One APB transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         mismatches++;
         end_sim();
      end
      // Answer taken at the edge that sees pready high
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   // Poll status until the sequencer reports done, bounded
   task automatic wait_done();
      for (int n = 0; n < 400; n++) begin
         apb(1'b0, wlc_pkg::WLC_STAT_OFS, 32'h0);
         if (rd[6:3] === wlc_pkg::WLC_DONE) return;
      end
      mismatches++;
      end_sim();
   endtask : wait_done
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(wlc_pkg::WLC_CFG_OFS, wlc_pkg::WLC_CFG_RST);
      rdchk(wlc_pkg::WLC_MR1_OFS, {14'h0, wlc_pkg::WLC_MR1_RST});
      rdchk(8'h14, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Every rate and gear, then latency off; termination and rank vary
      for (int k = 0; k < 9; k++) begin
         cfg = {18'h0, k[0], 1'b0, 2'h0, k[1:0], 3'h0, 1'b1, k < 8, k[2],
            k[1:0]};
         apb(1'b1, wlc_pkg::WLC_CFG_OFS, cfg);
         apb(1'b1, wlc_pkg::WLC_CTRL_OFS, 32'h1);
         apb(1'b1, wlc_pkg::WLC_CFG_OFS, 32'h0); // Refused while busy
         rdchk(wlc_pkg::WLC_CFG_OFS, cfg);
         wait_done();
         chk({30'h0, rd[1:0]}, 32'h3);
         rdchk(wlc_pkg::WLC_DLY_OFS, {16'h0, 8'(HI), 8'(LO)});
         chk({29'h0, i_dram.cal_r}, {29'h0, cal_code[k]});
         chk({28'h0, i_dram.wl_r}, 32'h0);
      end
      // Abort while the mode writes are still going out
      apb(1'b1, wlc_pkg::WLC_CTRL_OFS, 32'h1);
      apb(1'b1, wlc_pkg::WLC_CTRL_OFS, 32'h2);
      wait_done();
      chk({28'h0, i_dram.wl_r}, 32'h0);
      chk(32'(i_dram.viol), 32'h0);
      end_sim();
   end
endmodule : wlc_ctrl_bench
`default_nettype wire
